// *** design/spi_ctrl.sv ***
// Serial peripheral control, buffering and interrupt logic
// Notes on behaviour
// (R01) Request stays while enabled flag is set
// (R02) All sources share vector offset zero
// (R03) Deep sleep aborts transfer; idle keeps running
// (R04) Bit order: 0 MSB first, 1 LSB
// (R05) Role bit: 0 slave, 1 master
// (R06) Select low in master drops role, flags
// (R07) Select ignore bit keeps master role
// (R08) Clock double halves master SCK period
// (R09) Divider code gives clock/4,16,64,128
// (R10) Enable bit switches interface on
// (R11) Buffered mode: two rx, one tx buffer
// (R12) Without wait bit, first byte is dummy
// (R13) With wait bit, idle write loads shifter
// (R14) Mode field picks sample and setup edges
// (R15) SCK idles at leading edge's start level
// (R16) Rx done enable, zero when unbuffered
// (R17) Tx done enable, zero when unbuffered
// (R18) Tx empty enable, zero when unbuffered
// (R19) Select trigger enable, zero when unbuffered
// (R20) Unbuffered enable gates byte done flag
// (R21) Byte done clears on ack or read-access
// (R22) Write while busy sets collision, ignored
// (R23) Third byte with full buffers sets overrun
// (R24) Data read pops second rx buffer
// (R25) Eight bits per byte, full duplex
//
// Design decision made here: the strobed register port.
module spi_ctrl
  import spi_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic       arst_n_in,
  input  wire logic [2:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  input  wire logic       deep_sleep_in,
  input  wire logic       irq_ack_in,
  input  wire logic       sck_in,
  input  wire logic       mosi_in,
  input  wire logic       miso_in,
  input  wire logic       ss_n_in,
  output logic [7:0]      rdata_out,
  output logic            irq_out,
  output logic [7:0]      irq_vector_out,
  output spi_pins_t       pins_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_a_reg, ctrl_b_reg, ie_reg;
  logic [3:0]  sync1_reg, sync2_reg;
  logic        sck_d_reg;
  xfer_state_t st_reg;
  logic [3:0]  edge_cnt_reg;
  logic        sck_reg;
  logic [7:0]  sh_reg, rx_reg, tx_buf_reg, rx1_reg, rx2_reg;
  logic        sh_valid_reg, tx_full_reg;
  logic [1:0]  rx_cnt_reg, rx_cnt_mid;
  logic        if_reg, if_arm_reg, write_collision_flag_reg, write_collision_flag_arm_reg;
  logic        rxc_reg, txc_reg, select_trigger_flag_reg, ovf_reg;
  logic [7:0]  rx_next, flags_rd, ie_rd;
  logic        en, master, bit_order_select, buffered_operation_bit, buffer_wait_receive_bit, select_line_ignore_bit, cpol, cpha;
  logic        ss_s, sck_s, in_bit, tx_bit;
  logic        busy, ss_trig, abort, slave_sel, m_start, tick;
  logic        edge_ev, byte_done, sample;
  logic        wr_data, rd_data, data_acc, rd_flags, w1c, irq_cond;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  // Control fields
  assign en     = ctrl_a_reg[CA_ENABLE];     // see (R10)
  assign master = ctrl_a_reg[CA_MASTER];     // see (R05)
  assign bit_order_select   = ctrl_a_reg[CA_BIT_ORDER];
  assign buffered_operation_bit  = ctrl_b_reg[CB_BUFFERED];   // see (R11)
  assign buffer_wait_receive_bit  = ctrl_b_reg[CB_WAIT_RX];
  assign select_line_ignore_bit    = ctrl_b_reg[CB_SEL_IGN];
  assign cpol   = ctrl_b_reg[CB_MODE_HI];    // see (R14)
  assign cpha   = ctrl_b_reg[CB_MODE_LO];    // see (R14)

  // Bus strobes
  assign wr_data  = wr_in & (addr_in == OFS_DATA);
  assign rd_data  = rd_in & (addr_in == OFS_DATA);
  assign data_acc = wr_data | rd_data;
  assign rd_flags = rd_in & (addr_in == OFS_IRQ_FLAGS);
  assign w1c      = wr_in & (addr_in == OFS_IRQ_FLAGS);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Two flops per pin, plus an edge flop on SCK
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync1_reg <= 4'hf;
      sync2_reg <= 4'hf;
      sck_d_reg <= 1'b0;
    end else begin
      sync1_reg <= {ss_n_in, sck_in, mosi_in, miso_in};
      sync2_reg <= sync1_reg;
      sck_d_reg <= sync2_reg[2];
    end
  end

  assign ss_s   = sync2_reg[3];
  assign sck_s  = sync2_reg[2];
  assign in_bit = master ? sync2_reg[0] : sync2_reg[1];
  assign tx_bit = bit_order_select ? sh_reg[0] : sh_reg[7];    // see (R04)

  // ----------------------------------------------------------------
  // Transfer control
  // ----------------------------------------------------------------
  // Select trigger only when the line is not ignored
  assign ss_trig   = en & master & ~select_line_ignore_bit & ~ss_s;    // see (R06) (R07)
  assign slave_sel = en & ~master & ~ss_s;
  // Deep sleep, disable, role loss or slave deselect stop the byte
  assign abort   = deep_sleep_in | ~en | ss_trig | (~master & ss_s); // see (R03)
  assign busy    = (st_reg == ST_RUN) & (master | (edge_cnt_reg != 4'h0));
  assign m_start = en & master & ~abort & (sh_valid_reg | (buffered_operation_bit & tx_full_reg));
  assign edge_ev = (st_reg == ST_RUN) & ~abort & (master ? tick : (sck_s ^ sck_d_reg));
  assign byte_done = edge_ev & (edge_cnt_reg == LAST_EDGE);      // see (R25)
  // Even edges lead; sample on leading edge when phase is zero
  assign sample    = (edge_cnt_reg[0] == cpha);                   // see (R14)

  // Master rate generator, doubling ignored in slave role
  spi_sck_gen #(
    .CNT_W (HALF_W)
  ) u_sck_gen (
    .clock_in  (clock_in),
    .arst_n_in (arst_n_in),
    .run_in    ((st_reg == ST_RUN) & master & ~abort),
    .half_in   (half_cycles(ctrl_a_reg[CA_RATE_HI:CA_RATE_LO],
                            ctrl_a_reg[CA_DOUBLE])),              // see (R08) (R09)
    .tick_out  (tick)
  );

  // Byte state machine
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_reg <= ST_IDLE;
    end else begin
      unique case (st_reg)
        ST_IDLE: begin
          if (!abort && (m_start || slave_sel)) begin
            st_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (abort || (master && byte_done)) begin
            st_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Edge counter and master SCK level
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      edge_cnt_reg <= 4'h0;
      sck_reg      <= 1'b0;
    end else if (st_reg == ST_IDLE || abort) begin
      edge_cnt_reg <= 4'h0;
      sck_reg      <= cpol;                          // see (R15)
    end else if (edge_ev) begin
      edge_cnt_reg <= edge_cnt_reg + 4'h1;           // see (R25)
      sck_reg      <= ~sck_reg;
    end
  end

  // ----------------------------------------------------------------
  // Shift register and transmit buffer
  // ----------------------------------------------------------------
  // Received byte including a sample on the current edge
  always_comb begin
    rx_next = rx_reg;
    if (edge_ev && sample) begin
      rx_next = bit_order_select ? {in_bit, rx_reg[7:1]} : {rx_reg[6:0], in_bit}; // see (R04)
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sh_reg       <= REG_RESET;
      rx_reg       <= REG_RESET;
      tx_buf_reg   <= REG_RESET;
      sh_valid_reg <= 1'b0;
      tx_full_reg  <= 1'b0;
    end else begin
      rx_reg <= rx_next;
      // Setup edges move the next bit out, except the first leading one
      if (edge_ev && !sample && !(cpha && edge_cnt_reg == 4'h0)) begin
        sh_reg <= bit_order_select ? {1'b0, sh_reg[7:1]} : {sh_reg[6:0], 1'b0}; // see (R25)
      end
      if (deep_sleep_in || !en) begin
        sh_valid_reg <= 1'b0;
      end else if (byte_done) begin
        if (buffered_operation_bit && tx_full_reg) begin
          sh_reg       <= tx_buf_reg;                // see (R12)
          sh_valid_reg <= 1'b1;
          tx_full_reg  <= 1'b0;
        end else begin
          sh_valid_reg <= 1'b0;
        end
      end else if (st_reg == ST_IDLE && m_start && !sh_valid_reg) begin
        sh_valid_reg <= 1'b0;                        // see (R12)
      end
      // Writes; a collision write leaves the shifter untouched
      if (wr_data && !buffered_operation_bit && !busy) begin
        sh_reg       <= wdata_in;                    // see (R22)
        sh_valid_reg <= 1'b1;
      end else if (wr_data && buffered_operation_bit && !tx_full_reg) begin
        if (buffer_wait_receive_bit && en && ss_s && !busy && !sh_valid_reg) begin
          sh_reg       <= wdata_in;                  // see (R13)
          sh_valid_reg <= 1'b1;
        end else begin
          tx_buf_reg  <= wdata_in;                   // see (R11) (R12)
          tx_full_reg <= 1'b1;
        end
      end
      if (!buffered_operation_bit) begin
        tx_full_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive buffers
  // ----------------------------------------------------------------
  // Fill level after a possible read pop
  assign rx_cnt_mid = (buffered_operation_bit && rd_data && rx_cnt_reg != 2'h0) ?
                      rx_cnt_reg - 2'h1 : rx_cnt_reg;

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx1_reg    <= REG_RESET;
      rx2_reg    <= REG_RESET;
      rx_cnt_reg <= 2'h0;
    end else if (!buffered_operation_bit) begin
      rx_cnt_reg <= 2'h0;
      if (byte_done) begin
        rx2_reg <= rx_next;
      end
    end else begin
      if (rd_data && rx_cnt_reg == RX_FULL) begin
        rx2_reg <= rx1_reg;                          // see (R24)
      end
      rx_cnt_reg <= rx_cnt_mid;
      if (byte_done && rx_cnt_mid != RX_FULL) begin
        rx_cnt_reg <= rx_cnt_mid + 2'h1;
        if (rx_cnt_mid == 2'h0) begin
          rx2_reg <= rx_next;
        end else begin
          rx1_reg <= rx_next;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  // Unbuffered byte done and collision, cleared by read then access
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      if_reg        <= 1'b0;
      if_arm_reg    <= 1'b0;
      write_collision_flag_reg     <= 1'b0;
      write_collision_flag_arm_reg <= 1'b0;
    end else begin
      if_reg <= flag_upd(~buffered_operation_bit & (byte_done | ss_trig), if_reg,
                         irq_ack_in | (if_arm_reg & data_acc));     // see (R06) (R21)
      if_arm_reg <= (rd_flags & if_reg) | (if_arm_reg & ~data_acc);  // see (R21)
      write_collision_flag_reg <= flag_upd(~buffered_operation_bit & wr_data & busy, write_collision_flag_reg,
                            write_collision_flag_arm_reg & data_acc);              // see (R22)
      write_collision_flag_arm_reg <= (rd_flags & write_collision_flag_reg) | (write_collision_flag_arm_reg & ~data_acc);
    end
  end

  // Buffered flags, write one to clear; rx done also clears when empty, overrun on data read
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rxc_reg  <= 1'b0;
      txc_reg  <= 1'b0;
      select_trigger_flag_reg <= 1'b0;
      ovf_reg  <= 1'b0;
    end else begin
      rxc_reg  <= flag_upd(buffered_operation_bit & byte_done, rxc_reg,
                           (w1c & wdata_in[FL_RX_DONE]) | (rx_cnt_mid == 2'h0));
      txc_reg  <= flag_upd(buffered_operation_bit & byte_done & ~tx_full_reg, txc_reg,
                           w1c & wdata_in[FL_TX_DONE]);
      select_trigger_flag_reg <= flag_upd(buffered_operation_bit & ss_trig, select_trigger_flag_reg,
                           w1c & wdata_in[FL_SEL_TRIG]);            // see (R06)
      ovf_reg  <= flag_upd(buffered_operation_bit & byte_done & (rx_cnt_mid == RX_FULL), ovf_reg,
                           rd_data);                                // see (R23)
    end
  end

  // Readable flag and enable views
  always_comb begin
    flags_rd = 8'h00;
    flags_rd[FL_RX_DONE]  = buffered_operation_bit ? rxc_reg : if_reg;
    flags_rd[FL_TX_DONE]  = buffered_operation_bit ? txc_reg : write_collision_flag_reg;
    flags_rd[FL_TX_EMPTY] = buffered_operation_bit & ~tx_full_reg;
    flags_rd[FL_SEL_TRIG] = buffered_operation_bit & select_trigger_flag_reg;
    flags_rd[FL_OVERRUN]  = buffered_operation_bit & ovf_reg;
    ie_rd = ie_reg & {{4{buffered_operation_bit}}, 4'hf};             // see (R16) (R17) (R18) (R19)
  end

  // Enabled flags in bits 7:4, or unbuffered byte done, raise the single request
  assign irq_cond = buffered_operation_bit ? |(ie_rd[7:4] & flags_rd[7:4])  // see (R01) (R16) (R17)
                          : ie_reg[IE_UNBUF] & if_reg;     // see (R20)

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Software writes; select trigger drops the role bit afterwards
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_a_reg <= REG_RESET;
      ctrl_b_reg <= REG_RESET;
      ie_reg     <= REG_RESET;
    end else begin
      if (wr_in && addr_in == OFS_CONTROL_A) begin
        ctrl_a_reg <= wdata_in & CA_MASK;
      end
      if (wr_in && addr_in == OFS_CONTROL_B) begin
        ctrl_b_reg <= wdata_in & CB_MASK;
      end
      if (wr_in && addr_in == OFS_IRQ_ENABLE) begin
        ie_reg <= wdata_in & IE_MASK;
      end
      if (ss_trig) begin
        ctrl_a_reg[CA_MASTER] <= 1'b0;               // see (R06)
      end
    end
  end

  // Read data for one cycle; unmapped reads give zero
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      unique case (addr_in)
        OFS_CONTROL_A:  rdata_out <= ctrl_a_reg;
        OFS_CONTROL_B:  rdata_out <= ctrl_b_reg;
        OFS_IRQ_ENABLE: rdata_out <= ie_rd;
        OFS_IRQ_FLAGS:  rdata_out <= flags_rd;
        OFS_DATA:       rdata_out <= rx2_reg;        // see (R24)
        default:        rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_out        <= 1'b0;
      irq_vector_out <= 8'h00;
      pins_out       <= '0;
    end else begin
      irq_out          <= irq_cond;                  // see (R01)
      irq_vector_out   <= IRQ_VECTOR_OFS;            // see (R02)
      pins_out.sck     <= master ? sck_reg : cpol;   // see (R15)
      pins_out.sck_oe  <= en & master;
      pins_out.mosi    <= tx_bit;
      pins_out.mosi_oe <= en & master;
      pins_out.miso    <= tx_bit;
      pins_out.miso_oe <= en & ~master & ~ss_s;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);

  irq_follow_a: assert property (irq_cond |=> irq_out)                 // see (R01)
    else $error("request missing while enabled flag set");
  vector_zero_a: assert property (##1 irq_vector_out == 8'h00)         // see (R02)
    else $error("vector offset not zero");
  sleep_abort_a: assert property (deep_sleep_in |=> st_reg == ST_IDLE) // see (R03)
    else $error("deep sleep did not stop transfer");
  role_drop_a: assert property (ss_trig |=> !master && (if_reg || select_trigger_flag_reg)) // see (R06)
    else $error("select low did not drop master role");
  ignore_keep_a: assert property (en && master && select_line_ignore_bit && !ss_s && !wr_in // see (R07)
                                  |=> master)
    else $error("ignored select changed role");
  sck_idle_a: assert property (st_reg == ST_IDLE && master && !wr_in // see (R15)
                               |=> ##1 pins_out.sck == $past(cpol, 2))
    else $error("SCK idle level wrong");
  collision_a: assert property (wr_data && !buffered_operation_bit && busy && !edge_ev // see (R22)
                                |=> write_collision_flag_reg && $stable(sh_reg))
    else $error("collision flag not set");
  ie_zero_a: assert property (rd_in && addr_in == OFS_IRQ_ENABLE && !buffered_operation_bit // see (R16)
                              |=> rdata_out[7:4] == 4'h0)
    else $error("buffered enables visible when unbuffered");
  eight_bit_a: assert property (byte_done && master // see (R25)
                                |=> st_reg == ST_IDLE && edge_cnt_reg == 4'h0)
    else $error("byte did not end and rewind after sixteen edges");
  overrun_a: assert property (buffered_operation_bit && byte_done && rx_cnt_mid == 2'h2 // see (R23)
                              |=> ovf_reg)
    else $error("overrun not flagged");

  master_byte_c: cover property (master && byte_done);
  slave_byte_c: cover property (!master && byte_done);
  overrun_c: cover property (buffered_operation_bit && ovf_reg);

endmodule

// *** design/spi_pkg.sv ***
// Shared constants, types and helpers of the serial peripheral control block
package spi_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_CONTROL_A  = 3'h0;
  localparam logic [2:0] OFS_CONTROL_B  = 3'h1;
  localparam logic [2:0] OFS_IRQ_ENABLE = 3'h2;
  localparam logic [2:0] OFS_IRQ_FLAGS  = 3'h3;
  localparam logic [2:0] OFS_DATA       = 3'h4;

  // ----------------------------------------------------------------
  // Field positions, masks and reset values
  // ----------------------------------------------------------------
  localparam int CA_BIT_ORDER = 6;
  localparam int CA_MASTER    = 5;
  localparam int CA_DOUBLE    = 4;
  localparam int CA_RATE_HI   = 2;
  localparam int CA_RATE_LO   = 1;
  localparam int CA_ENABLE    = 0;
  localparam int CB_BUFFERED  = 7;
  localparam int CB_WAIT_RX   = 6;
  localparam int CB_SEL_IGN   = 2;
  localparam int CB_MODE_HI   = 1;
  localparam int CB_MODE_LO   = 0;
  localparam int FL_RX_DONE   = 7;
  localparam int FL_TX_DONE   = 6;
  localparam int FL_TX_EMPTY  = 5;
  localparam int FL_SEL_TRIG  = 4;
  localparam int FL_OVERRUN   = 0;
  localparam int IE_UNBUF     = 0;
  localparam logic [7:0] CA_MASK   = 8'h77;
  localparam logic [7:0] CB_MASK   = 8'hc7;
  localparam logic [7:0] IE_MASK   = 8'hf1;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Vector, byte framing and rate divider
  // ----------------------------------------------------------------
  localparam logic [7:0] IRQ_VECTOR_OFS = 8'h00;
  localparam logic [3:0] LAST_EDGE      = 4'hf;
  localparam logic [1:0] RX_FULL        = 2'h2;
  localparam int DIV_CODE0 = 4;
  localparam int DIV_CODE1 = 16;
  localparam int DIV_CODE2 = 64;
  localparam int DIV_CODE3 = 128;
  localparam int HALF_W    = 7;

  // Clocks per SCK half period for a divider code and doubling
  function automatic logic [HALF_W-1:0] half_cycles(input logic [1:0] code,
                                                    input logic       dbl);
    int div;
    unique case (code)
      2'h0: div = DIV_CODE0;
      2'h1: div = DIV_CODE1;
      2'h2: div = DIV_CODE2;
      2'h3: div = DIV_CODE3;
    endcase
    half_cycles = HALF_W'((div / 2) >> dbl);
  endfunction

  // Sticky flag update where the set beats the clear
  function automatic logic flag_upd(input logic set, input logic held,
                                    input logic clr);
    flag_upd = set | (held & ~clr);
  endfunction

  typedef enum logic {ST_IDLE, ST_RUN} xfer_state_t;

  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic mosi;
    logic mosi_oe;
    logic miso;
    logic miso_oe;
  } spi_pins_t;

endpackage

// *** design/spi_sck_gen.sv ***
// Master SCK half-period tick generator
module spi_sck_gen #(
  parameter int CNT_W = 7
) (
  input  wire logic             clock_in,
  input  wire logic             arst_n_in,
  input  wire logic             run_in,
  input  wire logic [CNT_W-1:0] half_in,
  output logic                  tick_out
);

  logic [CNT_W-1:0] cnt_reg;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (CNT_W < 7) begin : g_chk
    $error("spi_sck_gen: CNT_W too small for the slowest rate");
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // One tick each half period while running
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_reg  <= '0;
      tick_out <= 1'b0;
    end else if (!run_in) begin
      cnt_reg  <= '0;
      tick_out <= 1'b0;
    end else if (cnt_reg == half_in - CNT_W'(1)) begin
      cnt_reg  <= '0;
      tick_out <= 1'b1;
    end else begin
      cnt_reg  <= cnt_reg + CNT_W'(1);
      tick_out <= 1'b0;
    end
  end

endmodule

// *** tb/spi_far_slave.sv ***
// Behavioural far-side serial slave device, mode 0, eight-bit frames
module spi_far_slave (
  input  wire logic       sck_in,
  input  wire logic       sel_n_in,
  input  wire logic       mosi_in,
  input  wire logic [7:0] reply_in,
  output logic            miso_out,
  output logic [7:0]      got_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] tx;

  // ----------------------------------------------------------------
  // Frame start and release
  // ----------------------------------------------------------------
  initial begin
    miso_out = 1'b1;
    got_out  = 8'h00;
  end
  // First bit stands before the first edge
  always @(negedge sel_n_in) begin
    tx       = reply_in;
    miso_out = tx[7];
  end
  // Released line shows the inverse of its last level
  always @(posedge sel_n_in) miso_out = ~miso_out;

  // ----------------------------------------------------------------
  // Shifting
  // ----------------------------------------------------------------
  // Sample on the rising leading edge
  always @(posedge sck_in) if (!sel_n_in) got_out = {got_out[6:0], mosi_in};
  // Set up on the falling trailing edge
  always @(negedge sck_in) begin
    if (!sel_n_in) begin
      tx       = {tx[6:0], 1'b0};
      miso_out = tx[7];
    end
  end
endmodule

// *** tb/test_spi_ctrl.sv ***
// Register-level testbench of the serial peripheral control block
module test_spi_ctrl;
  import spi_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clock_in = 1'b0;
  logic       arst_n_in = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd_s = 1'b0;
  logic       deep_sleep = 1'b0;
  logic       irq_ack = 1'b0;
  logic       ss_n = 1'b1;
  logic       sel_n = 1'b1;
  logic [7:0] reply = 8'h00;
  logic [7:0] rdata_out;
  logic       irq_out;
  logic [7:0] irq_vector_out;
  spi_pins_t  pins_out;
  logic       miso;
  logic [7:0] got;
  int         err_count = 0;
  int         total_checks = 0;

  always #2 clock_in = ~clock_in;

  spi_ctrl i_spi_ctrl (.clock_in(clock_in), .arst_n_in(arst_n_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd_s), .deep_sleep_in(deep_sleep),
    .irq_ack_in(irq_ack), .sck_in(pins_out.sck), .mosi_in(pins_out.mosi), .miso_in(miso),
    .ss_n_in(ss_n), .rdata_out(rdata_out), .irq_out(irq_out),
    .irq_vector_out(irq_vector_out), .pins_out(pins_out));
  spi_far_slave i_spi_far_slave (.sck_in(pins_out.sck), .sel_n_in(sel_n),
    .mosi_in(pins_out.mosi), .reply_in(reply), .miso_out(miso), .got_out(got));

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    if (err_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got_v);
    total_checks++;
    if (got_v !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got_v);
    end
  endtask
  task automatic wrr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clock_in);
    wr <= 1'b0;
  endtask
  task automatic rdr(input logic [2:0] a, input logic [7:0] exp, input string nm);
    @(posedge clock_in);
    addr <= a; rd_s <= 1'b1;
    @(posedge clock_in);
    rd_s <= 1'b0;
    #1 chk(nm, exp, rdata_out);
  endtask
  // Bounded wait for the request line
  task automatic wait_irq();
    for (int i = 0; i < 300; i++) begin
      @(posedge clock_in);
      if (irq_out === 1'b1) return;
    end
    err_count++;
    $display("BAD irq_out expected 1 seen timeout");
    tally_and_finish();
  endtask
  // New frame at the far side with a given reply
  task automatic frame(input logic [7:0] r);
    sel_n <= 1'b1; reply <= r;
    repeat (2) @(posedge clock_in);
    sel_n <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clock_in);
    arst_n_in <= 1'b1;
    for (int a = 0; a < 8; a++) if (a != 4) rdr(3'(a), 8'h00, "reset value");
    wrr(OFS_CONTROL_A, 8'hff);
    rdr(OFS_CONTROL_A, 8'h77, "control_a");
    wrr(OFS_CONTROL_B, 8'hff);
    rdr(OFS_CONTROL_B, 8'hc7, "control_b");
    wrr(OFS_CONTROL_B, 8'h00);
    wrr(OFS_IRQ_ENABLE, 8'hff);
    rdr(OFS_IRQ_ENABLE, 8'h01, "unbuffered enables");
    chk("vector", 8'h00, irq_vector_out);
    // Plain master byte, MSB first; divide by 16 lets MISO pass the synchronisers
    frame(8'h3c);
    wrr(OFS_CONTROL_A, 8'h23);
    wrr(OFS_DATA, 8'ha5);
    wait_irq();
    chk("sent byte", 8'ha5, got);
    rdr(OFS_IRQ_FLAGS, 8'h80, "byte done");
    rdr(OFS_DATA, 8'h3c, "received byte");
    repeat (2) @(posedge clock_in);
    chk("irq after clear", 8'h00, {7'h00, irq_out});
    // Write while busy is dropped
    frame(8'h96);
    wrr(OFS_DATA, 8'h5a);
    wrr(OFS_DATA, 8'hff);
    wait_irq();
    rdr(OFS_IRQ_FLAGS, 8'hc0, "collision flags");
    chk("sent after collision", 8'h5a, got);
    rdr(OFS_DATA, 8'h96, "received byte");
    // LSB first in both directions
    frame(8'h0f);
    wrr(OFS_CONTROL_A, 8'h63);
    wrr(OFS_DATA, 8'h01);
    wait_irq();
    chk("lsb first sent", 8'h80, got);
    rdr(OFS_IRQ_FLAGS, 8'h80, "byte done");
    rdr(OFS_DATA, 8'hf0, "lsb first received");
    // Select low drops master role, ignore bit keeps it
    sel_n <= 1'b1;
    wrr(OFS_CONTROL_A, 8'h21);
    ss_n <= 1'b0;
    repeat (6) @(posedge clock_in);
    rdr(OFS_CONTROL_A, 8'h01, "role dropped");
    rdr(OFS_IRQ_FLAGS, 8'h80, "select flag");
    irq_ack <= 1'b1;
    @(posedge clock_in);
    irq_ack <= 1'b0;
    rdr(OFS_IRQ_FLAGS, 8'h00, "flag after ack");
    ss_n <= 1'b1;
    wrr(OFS_CONTROL_B, 8'h04);
    wrr(OFS_CONTROL_A, 8'h21);
    ss_n <= 1'b0;
    repeat (6) @(posedge clock_in);
    rdr(OFS_CONTROL_A, 8'h21, "role kept");
    ss_n <= 1'b1;
    // Deep sleep aborts a byte
    wrr(OFS_CONTROL_B, 8'h00);
    frame(8'h00);
    wrr(OFS_DATA, 8'ha5);
    repeat (6) @(posedge clock_in);
    deep_sleep <= 1'b1;
    repeat (80) @(posedge clock_in);
    rdr(OFS_IRQ_FLAGS, 8'h00, "aborted byte");
    deep_sleep <= 1'b0;
    // Buffered: direct load, one queued byte, then a third byte overruns
    wrr(OFS_CONTROL_B, 8'hc0);
    wrr(OFS_IRQ_ENABLE, 8'h40);
    frame(8'hc3);
    wrr(OFS_CONTROL_A, 8'h23);
    wrr(OFS_DATA, 8'h11);
    wrr(OFS_DATA, 8'h22);
    wait_irq();
    chk("buffered sent", 8'h22, got);
    wrr(OFS_IRQ_FLAGS, 8'h40);
    wrr(OFS_DATA, 8'h33);
    wait_irq();
    rdr(OFS_IRQ_FLAGS, 8'he1, "overrun flags");
    rdr(OFS_DATA, 8'hc3, "first rx buffer");
    rdr(OFS_DATA, 8'h00, "second rx buffer");
    rdr(OFS_IRQ_FLAGS, 8'h60, "flags after pops");
    // Falling leading edge idles high
    wrr(OFS_CONTROL_B, 8'h02);
    repeat (4) @(posedge clock_in);
    chk("idle sck", 8'h01, {7'h00, pins_out.sck});
    tally_and_finish();
  end
endmodule
